// file: egf_pkg.sv
`default_nettype none
package egf_pkg;

	localparam int REG_W   = 32;
	localparam int ADDR_W  = 12;
	localparam int VALUE_W = 12;
	localparam int TB_W    = 8;
	localparam int GCODE_W = 10;
	localparam int EXPUS_W = VALUE_W + TB_W;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] EXPOSURE_OFS   = 12'h81c;
	localparam logic [ADDR_W-1:0] GAIN_OFS       = 12'h820;
	localparam logic [ADDR_W-1:0] TIME_BASE_OFS  = 12'h900;
	localparam logic [ADDR_W-1:0] ERROR_OFS      = 12'h904;
	localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 12'h908;
	localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFS = 12'h90c;
	localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFS  = 12'h910;
	localparam logic [ADDR_W-1:0] EXPOSURE_US_OFS = 12'h914;
	localparam logic [ADDR_W-1:0] STATE_OFS      = 12'h918;

	// Field numbers count from the most significant end of the word
	localparam int MSB_POS      = REG_W - 1;
	localparam int PRESENT_POS  = MSB_POS - 0;
	localparam int ABS_POS      = MSB_POS - 1;
	localparam int ONE_PUSH_POS = MSB_POS - 5;
	localparam int ON_OFF_POS   = MSB_POS - 6;
	localparam int AUTO_POS     = MSB_POS - 7;
	localparam int VALUE_LSB    = MSB_POS - 31;

	localparam logic [VALUE_W-1:0] EXPOSURE_RESET  = 12'h1f4;
	localparam logic [VALUE_W-1:0] EXPOSURE_MIN    = 12'h001;
	localparam logic [VALUE_W-1:0] EXPOSURE_MAX    = 12'hfff;
	localparam logic [VALUE_W-1:0] GAIN_RESET      = 12'h172;
	localparam logic [VALUE_W-1:0] GAIN_MIN        = 12'h15e;
	localparam logic [VALUE_W-1:0] GAIN_MAX_NARROW = 12'h3ff;
	localparam logic [VALUE_W-1:0] GAIN_MAX_WIDE   = 12'h1ff;
	localparam logic [GCODE_W-1:0] GAIN_CODE_MAX   = 10'h3ff;

	localparam logic [TB_W-1:0] TIME_BASE_US_RESET = 8'h14;
	localparam int CLK_PERIOD_NS = 8;
	localparam int NS_PER_US     = 1000;
	localparam int CYC_PER_US    = (NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PRE_W         = $clog2(CYC_PER_US);

	localparam int ERR_W        = 2;
	localparam int ERR_EXP_BIT  = 0;
	localparam int ERR_GAIN_BIT = 1;
	localparam int IRQ_W         = 3;
	localparam int IRQ_EXP_ERR   = 0;
	localparam int IRQ_GAIN_ERR  = 1;
	localparam int IRQ_EXP_DONE  = 2;
	localparam int ST_ACTIVE_BIT = 0;
	localparam int ST_WIDE_BIT   = 1;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [REG_W-1:0]  wdata;
	} egf_bus_req_type;

endpackage : egf_pkg
`default_nettype wire

// file: egf_exposure_timer.sv
`default_nettype none
module egf_exposure_timer #(
	parameter int VALUE_W = egf_pkg::VALUE_W,
	parameter int TB_W    = egf_pkg::TB_W
) (
	input  wire logic               mclk,
	input  wire logic               nrst,
	input  wire logic               clk_en,
	input  wire logic               start,
	input  wire logic [VALUE_W-1:0] value,
	input  wire logic [TB_W-1:0]    time_base,
	output var  logic               active_q,
	output var  logic               done_q
);
	typedef enum logic [0:0] {EGF_IDLE, EGF_RUN} egf_tstate_type;

	localparam logic [egf_pkg::PRE_W-1:0] PRE_LAST = egf_pkg::PRE_W'(egf_pkg::CYC_PER_US - 1);

	egf_tstate_type              state_q, state_d;
	logic [egf_pkg::PRE_W-1:0]   pre_q, pre_d;
	logic [TB_W-1:0]             us_q, us_d;
	logic [VALUE_W-1:0]          units_q, units_d;
	logic [VALUE_W-1:0]          val_q, val_d;
	logic [TB_W-1:0]             tb_q, tb_d;
	logic                        active_d, done_d;

	// Length is value x time base x cycles per microsecond, latched at start
	always_comb begin
		state_d  = state_q;
		pre_d    = pre_q;
		us_d     = us_q;
		units_d  = units_q;
		val_d    = val_q;
		tb_d     = tb_q;
		done_d   = 1'b0;
		case (state_q)
			EGF_IDLE: begin
				if (start) begin
					val_d   = value;
					tb_d    = time_base;
					pre_d   = '0;
					us_d    = '0;
					units_d = '0;
					if (value == '0) begin
						done_d = 1'b1;
					end else begin
						state_d = EGF_RUN;
					end
				end
			end
			EGF_RUN: begin
				pre_d = pre_q + 1'b1;
				if (pre_q == PRE_LAST) begin
					pre_d = '0;
					us_d  = us_q + 1'b1;
					if (us_q == tb_q - 1'b1) begin
						us_d    = '0;
						units_d = units_q + 1'b1;
						if (units_q + 1'b1 == val_q) begin // R8
							state_d = EGF_IDLE;
							done_d  = 1'b1;
						end
					end
				end
			end
			default: begin
				state_d = EGF_IDLE;
			end
		endcase
		active_d = (state_d == EGF_RUN);
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_q  <= EGF_IDLE;
			pre_q    <= '0;
			us_q     <= '0;
			units_q  <= '0;
			val_q    <= '0;
			tb_q     <= '0;
			active_q <= 1'b0;
			done_q   <= 1'b0;
		end else if (clk_en) begin
			state_q  <= state_d;
			pre_q    <= pre_d;
			us_q     <= us_d;
			units_q  <= units_d;
			val_q    <= val_d;
			tb_q     <= tb_d;
			active_q <= active_d;
			done_q   <= done_d;
		end
	end

endmodule : egf_exposure_timer
`default_nettype wire

// file: egf_feature_regs.sv
// What this block does
// R1 - Bit 0 of both feature registers reads 1 as the presence flag and ignores writes.
// R2 - Bit 1 of both registers reads 0, so control is only through the value field, not an absolute_setting_register.
// R3 - Bit 5 of both registers reads 0 and ignores writes since single-shot adjustment is absent.
// R4 - Bit 6 of both registers reads 1 and writes cannot switch either feature off.
// R5 - Bit 7 of both registers reads 0 for manual control and ignores writes.
// R6 - Bits 2 to 4 and 8 to 19 of both registers read 0 and ignore writes.
// R7 - The exposure value sits in bits 20 to 31 and software keeps it between 1 and 4095.
// R8 - Exposure time is the stored exposure value times the time base; the value resets to 500.
// R9 - The time base resets to 20 microseconds and software may change it in its own register.
// R10 - The gain value sits in bits 20 to 31, resets to 370 and stays within 350 to 1023 for narrow formats.
// R11 - With a 16-bit pixel format software keeps the gain between 350 and 511.
// R12 - A gain value of 350 gives unity gain and 1023 gives the full 25.9 dB.
// R13 - A written value out of its range raises that feature's error flag while capture goes on.
// R14 - Bits are numbered from the top, so bit 0 is the word's most significant bit.
`default_nettype none
module egf_feature_regs #(
	parameter int TB_W = egf_pkg::TB_W
) (
	input  wire logic                          mclk,
	input  wire logic                          nrst,
	input  wire logic                          clk_en,
	input  wire egf_pkg::egf_bus_req_type      bus_req,
	output var  logic [egf_pkg::REG_W-1:0]     rdata_q,
	input  wire logic                          pixel_wide,
	input  wire logic                          exposure_start,
	output var  logic                          exposure_active_q,
	output var  logic [egf_pkg::VALUE_W-1:0]   exposure_value_q,
	output var  logic [TB_W-1:0]               time_base_q,
	output var  logic [egf_pkg::GCODE_W-1:0]   gain_code_q,
	output var  logic                          irq_q
);
	localparam int VW = egf_pkg::VALUE_W;
	localparam int RW = egf_pkg::REG_W;

	// Fixed flags and zero reserved bits above the live value field
	function automatic logic [RW-1:0] egf_feature_image(input logic [VW-1:0] value);
		logic [RW-1:0] img;
		img = '0; // R6
		img[egf_pkg::PRESENT_POS]  = 1'b1; // R1 R14
		img[egf_pkg::ABS_POS]      = 1'b0; // R2
		img[egf_pkg::ONE_PUSH_POS] = 1'b0; // R3
		img[egf_pkg::ON_OFF_POS]   = 1'b1; // R4
		img[egf_pkg::AUTO_POS]     = 1'b0; // R5
		img[egf_pkg::VALUE_LSB +: VW] = value;
		return img;
	endfunction : egf_feature_image

	function automatic logic [VW-1:0] egf_value_field(input logic [RW-1:0] word);
		return word[egf_pkg::VALUE_LSB +: VW]; // R7 R10 R14
	endfunction : egf_value_field

	function automatic logic egf_out_of_range(
		input logic [VW-1:0] value,
		input logic [VW-1:0] lo,
		input logic [VW-1:0] hi
	);
		return (value < lo) || (value > hi);
	endfunction : egf_out_of_range

	logic [VW-1:0]                   gain_q, gain_d;
	logic [VW-1:0]                   exposure_value_d;
	logic [TB_W-1:0]                 time_base_d;
	logic [egf_pkg::ERR_W-1:0]       err_q, err_d;
	logic [egf_pkg::IRQ_W-1:0]       irq_status_q, irq_status_d;
	logic [egf_pkg::IRQ_W-1:0]       irq_en_q, irq_en_d;
	logic                            irq_d;
	logic [RW-1:0]                   rdata_d;
	logic [egf_pkg::GCODE_W-1:0]     gain_code_d;
	logic [egf_pkg::EXPUS_W-1:0]     exposure_us_q, exposure_us_d;
	logic                            timer_active;
	logic                            timer_done;

	logic                            wr_exposure;
	logic                            wr_gain;
	logic                            wr_time_base;
	logic                            wr_irq_en;
	logic                            wr_irq_clr;
	logic [VW-1:0]                   wvalue;
	logic [VW-1:0]                   gain_max;
	logic                            exp_bad;
	logic                            gain_bad;
	logic [egf_pkg::IRQ_W-1:0]       irq_events;
	logic [egf_pkg::IRQ_W-1:0]       irq_clear;
	logic [VW-1:0]                   gain_above;

	// Write decode
	always_comb begin
		wr_exposure  = bus_req.wr && (bus_req.addr == egf_pkg::EXPOSURE_OFS);
		wr_gain      = bus_req.wr && (bus_req.addr == egf_pkg::GAIN_OFS);
		wr_time_base = bus_req.wr && (bus_req.addr == egf_pkg::TIME_BASE_OFS);
		wr_irq_en    = bus_req.wr && (bus_req.addr == egf_pkg::IRQ_ENABLE_OFS);
		wr_irq_clr   = bus_req.wr && (bus_req.addr == egf_pkg::IRQ_CLEAR_OFS);
		wvalue       = egf_value_field(bus_req.wdata);
		// The gain ceiling follows the pixel format in force at the write
		gain_max     = pixel_wide ? egf_pkg::GAIN_MAX_WIDE : egf_pkg::GAIN_MAX_NARROW; // R10 R11
		exp_bad      = egf_out_of_range(wvalue, egf_pkg::EXPOSURE_MIN,
			egf_pkg::EXPOSURE_MAX); // R7 R13
		gain_bad     = egf_out_of_range(wvalue, egf_pkg::GAIN_MIN, gain_max); // R13
	end

	// Feature values, error flags and the time base
	always_comb begin
		exposure_value_d = exposure_value_q;
		gain_d           = gain_q;
		time_base_d      = time_base_q;
		err_d            = err_q;
		// Out of range values are still stored; capture runs on with them
		if (wr_exposure) begin
			exposure_value_d = wvalue; // R8 R13
			err_d[egf_pkg::ERR_EXP_BIT] = exp_bad; // R13
		end
		if (wr_gain) begin
			gain_d = wvalue;
			err_d[egf_pkg::ERR_GAIN_BIT] = gain_bad; // R13
		end
		// A zero time base would wrap the exposure counter to 256 microseconds per step, so it is refused
		if (wr_time_base && (bus_req.wdata[TB_W-1:0] != '0)) begin
			time_base_d = bus_req.wdata[TB_W-1:0]; // R9
		end
		// Widen both factors first so the product keeps all of its bits
		exposure_us_d = egf_pkg::EXPUS_W'(exposure_value_d) *
			egf_pkg::EXPUS_W'(time_base_d); // R8
	end

	// Analog gain step: zero is unity, saturating at the top of the range
	always_comb begin
		gain_above = gain_d - egf_pkg::GAIN_MIN;
		if (gain_d < egf_pkg::GAIN_MIN) begin
			gain_code_d = '0; // R12
		end else if (gain_above > VW'(egf_pkg::GAIN_CODE_MAX)) begin
			gain_code_d = egf_pkg::GAIN_CODE_MAX; // R12
		end else begin
			gain_code_d = gain_above[egf_pkg::GCODE_W-1:0]; // R12
		end
	end

	// Sticky event bits; an event in the clearing cycle survives
	always_comb begin
		irq_events = '0;
		irq_events[egf_pkg::IRQ_EXP_ERR]  = wr_exposure && exp_bad;
		irq_events[egf_pkg::IRQ_GAIN_ERR] = wr_gain && gain_bad;
		irq_events[egf_pkg::IRQ_EXP_DONE] = timer_done;
		irq_clear = wr_irq_clr ? bus_req.wdata[egf_pkg::IRQ_W-1:0] : '0;
		irq_en_d  = wr_irq_en ? bus_req.wdata[egf_pkg::IRQ_W-1:0] : irq_en_q;
		irq_status_d = (irq_status_q & ~irq_clear) | irq_events;
		irq_d = |(irq_status_d & irq_en_d);
	end

	// Read port: data only in the cycle after the strobe, else zero
	always_comb begin
		rdata_d = '0;
		if (bus_req.rd) begin
			case (bus_req.addr)
				egf_pkg::EXPOSURE_OFS: begin
					rdata_d = egf_feature_image(exposure_value_q); // R1 R2 R3 R4 R5 R6
				end
				egf_pkg::GAIN_OFS: begin
					rdata_d = egf_feature_image(gain_q); // R1 R2 R3 R4 R5 R6
				end
				egf_pkg::TIME_BASE_OFS: begin
					rdata_d[TB_W-1:0] = time_base_q;
				end
				egf_pkg::ERROR_OFS: begin
					rdata_d[egf_pkg::ERR_W-1:0] = err_q;
				end
				egf_pkg::IRQ_STATUS_OFS: begin
					rdata_d[egf_pkg::IRQ_W-1:0] = irq_status_q;
				end
				egf_pkg::IRQ_ENABLE_OFS: begin
					rdata_d[egf_pkg::IRQ_W-1:0] = irq_en_q;
				end
				egf_pkg::EXPOSURE_US_OFS: begin
					rdata_d[egf_pkg::EXPUS_W-1:0] = exposure_us_q;
				end
				egf_pkg::STATE_OFS: begin
					rdata_d[egf_pkg::ST_ACTIVE_BIT] = timer_active;
					rdata_d[egf_pkg::ST_WIDE_BIT]   = pixel_wide;
				end
				default: begin
					rdata_d = '0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			exposure_value_q <= egf_pkg::EXPOSURE_RESET; // R8
			gain_q           <= egf_pkg::GAIN_RESET; // R10
			time_base_q      <= egf_pkg::TIME_BASE_US_RESET; // R9
			err_q            <= '0;
			irq_status_q     <= '0;
			irq_en_q         <= '0;
			irq_q            <= 1'b0;
			rdata_q          <= '0;
			gain_code_q      <= egf_pkg::GCODE_W'(egf_pkg::GAIN_RESET - egf_pkg::GAIN_MIN);
			exposure_us_q    <= egf_pkg::EXPUS_W'(egf_pkg::EXPOSURE_RESET) *
				egf_pkg::EXPUS_W'(egf_pkg::TIME_BASE_US_RESET);
			exposure_active_q <= 1'b0;
		end else if (clk_en) begin
			exposure_value_q <= exposure_value_d;
			gain_q           <= gain_d;
			time_base_q      <= time_base_d;
			err_q            <= err_d;
			irq_status_q     <= irq_status_d;
			irq_en_q         <= irq_en_d;
			irq_q            <= irq_d;
			rdata_q          <= rdata_d;
			gain_code_q      <= gain_code_d;
			exposure_us_q    <= exposure_us_d;
			exposure_active_q <= timer_active;
		end
	end

	// Exposure length is value x time base, taken when the exposure starts
	egf_exposure_timer #(
		.VALUE_W (VW),
		.TB_W    (TB_W)
	) u_timer (
		.mclk      (mclk),
		.nrst      (nrst),
		.clk_en    (clk_en),
		.start     (exposure_start),
		.value     (exposure_value_q),
		.time_base (time_base_q),
		.active_q  (timer_active),
		.done_q    (timer_done)
	); // R8 R9

endmodule : egf_feature_regs
`default_nettype wire

// file: egf_feature_regs_asserts.sv
`default_nettype none
module egf_feature_regs_asserts #(
	parameter int TB_W = egf_pkg::TB_W
) (
	input wire logic                        mclk,
	input wire logic                        nrst,
	input wire logic                        clk_en,
	input wire egf_pkg::egf_bus_req_type    bus_req,
	input wire logic [egf_pkg::REG_W-1:0]   rdata_q,
	input wire logic                        pixel_wide,
	input wire logic                        exposure_start,
	input wire logic                        exposure_active_q,
	input wire logic [egf_pkg::VALUE_W-1:0] exposure_value_q,
	input wire logic [TB_W-1:0]             time_base_q,
	input wire logic [egf_pkg::GCODE_W-1:0] gain_code_q,
	input wire logic                        irq_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	wire logic        wr_c = clk_en && bus_req.wr;
	wire logic        rd_c = clk_en && bus_req.rd;
	wire logic [11:0] wv   = bus_req.wdata[11:0];
	wire logic        tb_w = wr_c && bus_req.addr == egf_pkg::TIME_BASE_OFS;
	wire logic        g_ok = !pixel_wide && wv >= egf_pkg::GAIN_MIN
		&& wv <= egf_pkg::GAIN_MAX_NARROW;
	logic [egf_pkg::GCODE_W-1:0] code_q;
	// Expected step is held so the check can span the write and the output register
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			code_q <= '0;
		end else if (wr_c && bus_req.addr == egf_pkg::GAIN_OFS) begin
			code_q <= 10'(wv - egf_pkg::GAIN_MIN);
		end
	end
	sequence s_rd(a);
		rd_c && bus_req.addr == a;
	endsequence
	sequence s_gain_wr;
		wr_c && bus_req.addr == egf_pkg::GAIN_OFS && g_ok;
	endsequence
	AST_EXP_FLAGS: assert property (s_rd(egf_pkg::EXPOSURE_OFS)
		|=> rdata_q[31:12] == 20'h82000)
		else $error("exposure fixed bits wrong");
	AST_GAIN_FLAGS: assert property (s_rd(egf_pkg::GAIN_OFS)
		|=> rdata_q[31:12] == 20'h82000)
		else $error("gain fixed bits wrong");
	AST_EXP_VAL: assert property (s_rd(egf_pkg::EXPOSURE_OFS)
		|=> rdata_q[11:0] == $past(exposure_value_q))
		else $error("exposure value field wrong");
	AST_EXP_WR: assert property (wr_c && bus_req.addr == egf_pkg::EXPOSURE_OFS
		|=> exposure_value_q == $past(wv))
		else $error("exposure value not stored");
	AST_GAIN_CODE: assert property (s_gain_wr |-> ##2 gain_code_q == code_q)
		else $error("gain step wrong");
	AST_TB_SET: assert property (tb_w && wv[7:0] != 8'h00
		|=> time_base_q == $past(wv[TB_W-1:0]))
		else $error("time base not stored");
	AST_TB_ZERO: assert property (tb_w && wv[7:0] == 8'h00 |=> $stable(time_base_q))
		else $error("zero time base taken");
	AST_RD_IDLE: assert property (clk_en && !bus_req.rd |=> rdata_q == '0)
		else $error("read data outside read slot");
	AST_RUN_MIN: assert property ($rose(exposure_active_q) |-> exposure_active_q [*8])
		else $error("exposure too short");
endmodule : egf_feature_regs_asserts
bind egf_feature_regs egf_feature_regs_asserts #(.TB_W(TB_W)) u_chk (
	.mclk(mclk), .nrst(nrst), .clk_en(clk_en), .bus_req(bus_req), .rdata_q(rdata_q),
	.pixel_wide(pixel_wide), .exposure_start(exposure_start),
	.exposure_active_q(exposure_active_q), .exposure_value_q(exposure_value_q),
	.time_base_q(time_base_q), .gain_code_q(gain_code_q), .irq_q(irq_q));
`default_nettype wire

// file: egf_host_model.sv
`default_nettype none
module egf_host_model (
	input  wire logic                     mclk,
	input  wire logic [31:0]              rdata_q,
	output var  egf_pkg::egf_bus_req_type bus_req
);
	timeunit 1ns;
	timeprecision 1ps;
	initial bus_req = '0;
	// Values stay in range unless a test means otherwise
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk);
		bus_req <= '0;
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge mclk);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge mclk);
		bus_req <= '0;
		@(negedge mclk);
		d = rdata_q;
	endtask : rd
endmodule : egf_host_model
`default_nettype wire

// file: tb_egf_feature_regs.sv
`default_nettype none
module tb_egf_feature_regs;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [11:0] wa;
		logic [31:0] wd;
		logic [11:0] ra;
		logic [31:0] rx;
	} egf_row_type;
	egf_row_type rows [8] = '{
		'{12'h81c, 32'hffff_f7d0, 12'h81c, 32'h8200_07d0},
		'{12'h81c, 32'h0000_0000, 12'h81c, 32'h8200_0000},
		'{12'h904, 32'hffff_ffff, 12'h904, 32'h0000_0001},
		'{12'h820, 32'h0000_03ff, 12'h904, 32'h0000_0001},
		'{12'h820, 32'hffff_f15d, 12'h820, 32'h8200_015d},
		'{12'h81c, 32'h0000_0fff, 12'h904, 32'h0000_0002},
		'{12'h900, 32'h0000_0000, 12'h900, 32'h0000_0014},
		'{12'h7fc, 32'hffff_ffff, 12'h7fc, 32'h0000_0000}};
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic clk_en = 1'b1;
	logic pixel_wide = 1'b0;
	logic exposure_start = 1'b0;
	logic exposure_active_q;
	logic irq_q;
	logic [31:0] rdata_q;
	logic [11:0] exposure_value_q;
	logic [7:0]  time_base_q;
	logic [9:0]  gain_code_q;
	egf_pkg::egf_bus_req_type bus_req;
	int fail_count = 0;
	int cmp_count = 0;
	int n;
	always #4 mclk = ~mclk;
	egf_host_model u_host (.mclk(mclk), .rdata_q(rdata_q), .bus_req(bus_req));
	egf_feature_regs u_dut (
		.mclk(mclk), .nrst(nrst), .clk_en(clk_en), .bus_req(bus_req), .rdata_q(rdata_q),
		.pixel_wide(pixel_wide), .exposure_start(exposure_start),
		.exposure_active_q(exposure_active_q), .exposure_value_q(exposure_value_q),
		.time_base_q(time_base_q), .gain_code_q(gain_code_q), .irq_q(irq_q));
	task automatic chk_word(input logic [31:0] got, input logic [31:0] want);
		cmp_count++;
		if (got !== want) begin
			fail_count++;
			$display("unexpected at %0t: word %h, wanted %h", $time, got, want);
		end
	endtask : chk_word
	task automatic chk_bit(input logic got, input logic want);
		cmp_count++;
		if (got !== want) begin
			fail_count++;
			$display("unexpected at %0t: flag %b, wanted %b", $time, got, want);
		end
	endtask : chk_bit
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] want);
		logic [31:0] d;
		u_host.rd(a, d);
		chk_word(d, want);
	endtask : rd_chk
	task automatic do_reset();
		@(posedge mclk);
		nrst <= 1'b0;
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		@(negedge mclk);
		chk_word(32'(exposure_value_q), 32'h1f4);
		chk_word(32'(time_base_q), 32'h14);
		chk_word(32'(gain_code_q), 32'h14);
		rd_chk(egf_pkg::EXPOSURE_OFS, 32'h8200_01f4);
		rd_chk(egf_pkg::GAIN_OFS, 32'h8200_0172);
	endtask : do_reset
	task automatic end_sim();
		$display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim
	initial begin
		#20000;
		fail_count++;
		end_sim();
	end
	initial begin
		do_reset();
		for (int i = 0; i < 8; i++) begin
			u_host.wr(rows[i].wa, rows[i].wd);
			rd_chk(rows[i].ra, rows[i].rx);
		end
		@(posedge mclk);
		pixel_wide <= 1'b1;
		u_host.wr(egf_pkg::GAIN_OFS, 32'h200);
		rd_chk(egf_pkg::ERROR_OFS, 32'h2);
		u_host.wr(egf_pkg::GAIN_OFS, 32'h15e);
		rd_chk(egf_pkg::ERROR_OFS, 32'h0);
		chk_word(32'(gain_code_q), 32'h0);
		@(posedge mclk);
		pixel_wide <= 1'b0;
		u_host.wr(egf_pkg::GAIN_OFS, 32'h3ff);
		rd_chk(egf_pkg::ERROR_OFS, 32'h0);
		chk_word(32'(gain_code_q), 32'h2a1);
		rd_chk(egf_pkg::IRQ_STATUS_OFS, 32'h3);
		chk_bit(irq_q, 1'b0);
		u_host.wr(egf_pkg::IRQ_ENABLE_OFS, 32'h6);
		@(negedge mclk);
		chk_bit(irq_q, 1'b1);
		u_host.wr(egf_pkg::IRQ_CLEAR_OFS, 32'h7);
		@(negedge mclk);
		chk_bit(irq_q, 1'b0);
		u_host.wr(egf_pkg::EXPOSURE_OFS, 32'h1);
		u_host.wr(egf_pkg::TIME_BASE_OFS, 32'h1);
		exposure_start <= 1'b1;
		n = 0;
		// A second start inside the run must not stretch it
		for (int k = 0; k < 300; k++) begin
			@(posedge mclk);
			exposure_start <= (k == 2);
			@(negedge mclk);
			if (exposure_active_q === 1'b1) begin
				n++;
			end
		end
		chk_word(32'(n), 32'h7d);
		repeat (2) @(negedge mclk);
		chk_bit(irq_q, 1'b1);
		rd_chk(egf_pkg::IRQ_STATUS_OFS, 32'h4);
		rd_chk(egf_pkg::EXPOSURE_US_OFS, 32'h1);
		// With the enable low a write must leave no trace
		@(posedge mclk);
		clk_en <= 1'b0;
		u_host.wr(egf_pkg::EXPOSURE_OFS, 32'h2);
		clk_en <= 1'b1;
		rd_chk(egf_pkg::EXPOSURE_OFS, 32'h8200_0001);
		do_reset();
		end_sim();
	end
endmodule : tb_egf_feature_regs
`default_nettype wire
